/* File: core_control_pkg.sv */
`default_nettype none

package core_control_pkg;

    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] CORE_CONTROL_OFFSET = 8'h00;

    // field positions in the core control word
    localparam int VAR_LATENCY_BIT = 15;
    localparam int UNIMPL_BIT = 14;
    localparam int SIGNEDNESS_HI = 13;
    localparam int SIGNEDNESS_LO = 12;
    localparam int EARLY_TERM_BIT = 11;
    localparam int DEPTH_HI = 10;
    localparam int DEPTH_LO = 8;
    localparam int ACC_A_SAT_BIT = 7;
    localparam int ACC_B_SAT_BIT = 6;
    localparam int DS_WRITE_SAT_BIT = 5;
    localparam int SAT_MODE_BIT = 4;
    localparam int PRIO_MSB_BIT = 3;

    // field encodings and limits
    localparam logic [1:0] SIGNEDNESS_SIGNED = 2'h0;
    localparam logic [1:0] SIGNEDNESS_UNSIGNED = 2'h1;
    localparam logic [2:0] DEPTH_NONE = 3'h0;
    localparam logic [2:0] DEPTH_MAX = 3'h7;
    localparam logic [DATA_W-1:0] CORE_CONTROL_RESET = 16'h0020;

    // software-visible settings that steer the dsp engine and cpu
    typedef struct packed {
        logic varLatency;
        logic [1:0] multiplySignedness;
        logic accASaturateEnable;
        logic accBSaturateEnable;
        logic dataspaceWriteSaturateEnable;
        logic saturationModeSelect;
    } dsp_mode_t;

    // one register bus access
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // loop sequencer events from the core
    typedef struct packed {
        logic enter;
        logic exit;
    } loop_event_t;

endpackage

`default_nettype wire

/* File: loop_depth_tracker.sv */
`timescale 1ns/100ps
`default_nettype none

module loop_depth_tracker (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // loop events
    input wire core_control_pkg::loop_event_t loopEvent,
    // nesting count
    output logic [2:0] depth
);

    logic [2:0] depth_q;
    logic [2:0] depth_d;

    // count up on loop entry, down on loop exit, never wrap
    always_comb begin
        depth_d = depth_q;
        if (loopEvent.enter && !loopEvent.exit && depth_q != core_control_pkg::DEPTH_MAX) begin
            depth_d = depth_q + 3'h1;
        end else if (loopEvent.exit && !loopEvent.enter &&
                     depth_q != core_control_pkg::DEPTH_NONE) begin
            depth_d = depth_q - 3'h1;
        end
    end

    // nesting counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            depth_q <= core_control_pkg::DEPTH_NONE;
        end else if (ce) begin
            depth_q <= depth_d; // R4
        end
    end

    assign depth = depth_q;

endmodule

`default_nettype wire

/* File: core_control.sv */
// Contract
// (R1) Bit 15 set selects variable exception latency, clear selects fixed latency.
// (R2) Bits 13-12 at 01 make multiplies unsigned and at 00 make them signed.
// (R3) Writing 1 to bit 11 ends the running loop after its current iteration; it reads 0.
// (R4) Bits 10-8 are read-only and report how many loops are active, 000 meaning none.
// (R5) Bit 7 enables accumulator A saturation and resets to 0.
// (R6) Bit 6 enables accumulator B saturation and resets to 0.
// (R7) Bit 5 enables saturation of engine writes to data space and resets to 1.
// (R8) Bit 4 set picks super saturation, clear picks normal saturation.
// (R9) Bit 3 is the top priority bit joined above status bits 7-5; software may only clear it.
// (R10) Writes to the nesting field and to bit 14 are ignored and bit 14 reads 0.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module core_control (
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // register port
    input wire core_control_pkg::reg_req_t regReq,
    output logic [15:0] rdata,
    // core status inputs
    input wire core_control_pkg::loop_event_t loopEvent,
    input wire logic [2:0] statusWordPriority,
    input wire logic priorityMsbSet,
    // settings to the engine and cpu
    output core_control_pkg::dsp_mode_t dspMode,
    output logic multiplyUnsigned,
    output logic earlyLoopTerminate,
    output logic [2:0] loopNestingDepth,
    output logic [3:0] cpuPriorityLevel
);

    logic rstSync1_q;
    logic rstn_q;
    logic varLatency_q;
    logic [1:0] signedness_q;
    logic accASat_q;
    logic accBSat_q;
    logic dsWriteSat_q;
    logic satMode_q;
    logic prioMsb_q;
    logic prioMsb_d;
    logic earlyTerm_q;
    logic multUnsigned_q;
    logic [2:0] depthOut_q;
    logic [3:0] cpuPrio_q;
    logic [15:0] rdata_q;
    logic [15:0] readback;
    logic [2:0] depth;
    logic hit;
    logic wrHit;
    logic rdHit;

    // reset release through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstSync1_q <= 1'b0;
            rstn_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstn_q <= rstSync1_q;
        end
    end

    // address decode
    assign hit = regReq.addr == core_control_pkg::CORE_CONTROL_OFFSET;
    assign wrHit = hit && regReq.wr;
    assign rdHit = hit && regReq.rd;

    // loop nesting counter
    loop_depth_tracker depthTracker (
        .clk(clk),
        .rstn(rstn_q),
        .ce(ce),
        .loopEvent(loopEvent),
        .depth(depth)
    );

    // exception latency select
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            varLatency_q <=
                core_control_pkg::CORE_CONTROL_RESET[core_control_pkg::VAR_LATENCY_BIT];
        end else if (ce && wrHit) begin
            varLatency_q <= regReq.wdata[core_control_pkg::VAR_LATENCY_BIT]; // R1
        end
    end

    // multiply signedness field, codes 10 and 11 kept as written
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            signedness_q <= core_control_pkg::SIGNEDNESS_SIGNED;
        end else if (ce && wrHit) begin
            signedness_q <= regReq.wdata[core_control_pkg::SIGNEDNESS_HI:
                                         core_control_pkg::SIGNEDNESS_LO]; // R2
        end
    end

    // accumulator a saturation enable
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            accASat_q <= core_control_pkg::CORE_CONTROL_RESET[core_control_pkg::ACC_A_SAT_BIT];
        end else if (ce && wrHit) begin
            accASat_q <= regReq.wdata[core_control_pkg::ACC_A_SAT_BIT]; // R5
        end
    end

    // accumulator b saturation enable
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            accBSat_q <= core_control_pkg::CORE_CONTROL_RESET[core_control_pkg::ACC_B_SAT_BIT];
        end else if (ce && wrHit) begin
            accBSat_q <= regReq.wdata[core_control_pkg::ACC_B_SAT_BIT]; // R6
        end
    end

    // data space write saturation, the one setting that wakes up set
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            dsWriteSat_q <=
                core_control_pkg::CORE_CONTROL_RESET[core_control_pkg::DS_WRITE_SAT_BIT]; // R7
        end else if (ce && wrHit) begin
            dsWriteSat_q <= regReq.wdata[core_control_pkg::DS_WRITE_SAT_BIT]; // R7
        end
    end

    // saturation mode, super when set
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            satMode_q <= core_control_pkg::CORE_CONTROL_RESET[core_control_pkg::SAT_MODE_BIT];
        end else if (ce && wrHit) begin
            satMode_q <= regReq.wdata[core_control_pkg::SAT_MODE_BIT]; // R8
        end
    end

    // priority msb: hardware sets, software writes 0 to clear, set wins
    always_comb begin
        prioMsb_d = prioMsb_q;
        if (wrHit && !regReq.wdata[core_control_pkg::PRIO_MSB_BIT]) begin
            prioMsb_d = 1'b0; // R9
        end
        if (priorityMsbSet) begin
            prioMsb_d = 1'b1; // R9
        end
    end

    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            prioMsb_q <= 1'b0;
        end else if (ce) begin
            prioMsb_q <= prioMsb_d;
        end
    end

    // one-cycle terminate request, never stored as a readable bit
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            earlyTerm_q <= 1'b0;
        end else if (ce) begin
            earlyTerm_q <= wrHit && regReq.wdata[core_control_pkg::EARLY_TERM_BIT]; // R3
        end
    end

    // unsigned multiply flag, raised by code 01 only
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            multUnsigned_q <= 1'b0;
        end else if (ce) begin
            multUnsigned_q <= signedness_q == core_control_pkg::SIGNEDNESS_UNSIGNED; // R2
        end
    end

    // nesting depth copy for the core
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            depthOut_q <= core_control_pkg::DEPTH_NONE;
        end else if (ce) begin
            depthOut_q <= depth; // R4
        end
    end

    // four-bit cpu priority level, msb above the status bits
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            cpuPrio_q <= 4'h0;
        end else if (ce) begin
            cpuPrio_q <= {prioMsb_q, statusWordPriority}; // R9
        end
    end

    // readback word: bit 14, bit 11 and bits 2-0 read zero
    always_comb begin
        readback = 16'h0000; // R10
        readback[core_control_pkg::VAR_LATENCY_BIT] = varLatency_q;
        readback[core_control_pkg::SIGNEDNESS_HI:core_control_pkg::SIGNEDNESS_LO] = signedness_q;
        readback[core_control_pkg::EARLY_TERM_BIT] = 1'b0; // R3
        readback[core_control_pkg::DEPTH_HI:core_control_pkg::DEPTH_LO] = depth; // R4
        readback[core_control_pkg::ACC_A_SAT_BIT] = accASat_q;
        readback[core_control_pkg::ACC_B_SAT_BIT] = accBSat_q;
        readback[core_control_pkg::DS_WRITE_SAT_BIT] = dsWriteSat_q;
        readback[core_control_pkg::SAT_MODE_BIT] = satMode_q;
        readback[core_control_pkg::PRIO_MSB_BIT] = prioMsb_q;
    end

    // read data stand for one cycle only, zero elsewhere or when unmapped
    always_ff @(posedge clk or negedge rstn_q) begin
        if (!rstn_q) begin
            rdata_q <= 16'h0000;
        end else if (ce) begin
            rdata_q <= rdHit ? readback : 16'h0000;
        end
    end

    // output wiring straight from flops
    assign rdata = rdata_q;
    assign dspMode.varLatency = varLatency_q;
    assign dspMode.multiplySignedness = signedness_q;
    assign dspMode.accASaturateEnable = accASat_q;
    assign dspMode.accBSaturateEnable = accBSat_q;
    assign dspMode.dataspaceWriteSaturateEnable = dsWriteSat_q;
    assign dspMode.saturationModeSelect = satMode_q;
    assign multiplyUnsigned = multUnsigned_q;
    assign earlyLoopTerminate = earlyTerm_q;
    assign loopNestingDepth = depthOut_q;
    assign cpuPriorityLevel = cpuPrio_q;

endmodule

`default_nettype wire

/* File: core_control_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module core_control_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // register port and core status
    input wire core_control_pkg::reg_req_t regReq,
    input wire logic [15:0] rdata,
    input wire core_control_pkg::loop_event_t loopEvent,
    input wire logic [2:0] statusWordPriority,
    input wire logic priorityMsbSet,
    // settings out
    input wire core_control_pkg::dsp_mode_t dspMode,
    input wire logic multiplyUnsigned,
    input wire logic earlyLoopTerminate,
    input wire logic [2:0] loopNestingDepth,
    input wire logic [3:0] cpuPriorityLevel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // the mapped word, and a write taken there
    wire mapped = regReq.addr == core_control_pkg::CORE_CONTROL_OFFSET;
    wire hit = ce && regReq.wr && mapped;
    // register behaviour
    early_pulse_a: assert property (hit && regReq.wdata[11] |=> earlyLoopTerminate)
        else $error("early pulse missing");
    early_single_a: assert property (ce && !(hit && regReq.wdata[11])
        |=> !earlyLoopTerminate)
        else $error("early pulse too long");
    read_blank_a: assert property (ce && regReq.rd |=> !rdata[14] && !rdata[11])
        else $error("blank bits read set");
    read_depth_a: assert property (ce && regReq.rd && mapped
        |=> rdata[10:8] == loopNestingDepth)
        else $error("depth readback wrong");
    mode_fields_a: assert property (hit
        |=> dspMode == {$past(regReq.wdata[15]), $past(regReq.wdata[13:12]),
        $past(regReq.wdata[7:4])})
        else $error("mode fields wrong");
    unsigned_flag_a: assert property (ce
        |=> multiplyUnsigned == ($past(dspMode.multiplySignedness) == 2'h1))
        else $error("unsigned flag wrong");
    level_low_a: assert property (ce |=> cpuPriorityLevel[2:0] == $past(statusWordPriority))
        else $error("priority low bits wrong");
    msb_set_a: assert property (ce && priorityMsbSet ##1 ce |=> cpuPriorityLevel[3])
        else $error("priority msb not set");
    msb_clear_a: assert property (hit && !regReq.wdata[3] && !priorityMsbSet
        ##1 ce && !priorityMsbSet |=> !cpuPriorityLevel[3])
        else $error("priority msb not cleared");
    // main scenarios
    cover property (hit && regReq.wdata[11]);
    cover property (loopNestingDepth == 3'h7);
    cover property (ce && priorityMsbSet);
    cover property (hit && !regReq.wdata[3] && priorityMsbSet);
endmodule
bind core_control core_control_monitor mon (.*);
`default_nettype wire

/* File: core_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module core_control_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic priorityMsbSet = 1'b0;
    logic [2:0] statusWordPriority = 3'h0;
    core_control_pkg::reg_req_t regReq = '0;
    core_control_pkg::loop_event_t loopEvent = '0;
    core_control_pkg::dsp_mode_t dspMode;
    logic [15:0] rdata;
    logic multiplyUnsigned;
    logic earlyLoopTerminate;
    logic [2:0] loopNestingDepth;
    logic [3:0] cpuPriorityLevel;
    logic [15:0] stored = 16'h0020;
    logic [2:0] depth = 3'h0;
    logic msb = 1'b0;
    logic [31:0] seed = 32'h64663D18;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #10 clk = ~clk;
    core_control uut (.*);
    // next pseudo-random value and expected readback
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] expWord();
        return {stored[15], 1'b0, stored[13:12], 1'b0, depth, stored[7:4], msb, 3'h0};
    endfunction
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one-cycle register accesses
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        regReq.wr <= 1'b0;
        if (ce && a == 8'h00) begin
            stored = d;
            msb = msb & d[3];
        end
        #1;
        check("early", {15'h0, earlyLoopTerminate}, {15'h0, ce && a == 8'h00 && d[11]});
    endtask
    task automatic read(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        regReq <= '{a, 16'h0, 1'b0, 1'b1};
        @(posedge clk);
        regReq.rd <= 1'b0;
        #1;
        check("rdata", rdata, exp);
    endtask
    task automatic outs();
        check("mode", {9'h0, dspMode}, {9'h0, stored[15], stored[13:12], stored[7:4]});
        check("unsigned", {15'h0, multiplyUnsigned}, {15'h0, stored[13:12] == 2'h1});
        check("depth", {13'h0, loopNestingDepth}, {13'h0, depth});
        check("level", {12'h0, cpuPriorityLevel}, {12'h0, msb, statusWordPriority});
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        read(8'h00, 16'h0020);
        outs();
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            @(posedge clk);
            statusWordPriority <= seed[18:16];
            write(8'h00, i < 4 ? {seed[15:14], i[1:0], seed[11:0]} : seed[15:0]);
            read(8'h00, expWord());
            outs();
        end
        // hardware set meets a clearing write at one edge: set wins
        @(posedge clk);
        priorityMsbSet <= 1'b1;
        write(8'h00, stored & 16'hFFF7);
        @(posedge clk);
        priorityMsbSet <= 1'b0;
        msb = 1'b1;
        for (int i = 0; i < 2; i++) begin
            write(8'h00, i == 0 ? stored | 16'h0008 : stored & 16'hFFF7);
            read(8'h00, expWord());
            outs();
        end
        // fill past the ceiling, then drain past empty
        for (int n = 0; n < 2; n++) begin
            for (int i = 0; i < 8; i++) begin
                @(posedge clk);
                loopEvent <= n == 0 ? 2'b10 : 2'b01;
            end
            @(posedge clk);
            loopEvent <= 2'b00;
            depth = n == 0 ? 3'h7 : 3'h0;
            read(8'h00, expWord());
            outs();
        end
        write(8'h05, 16'hFFFF);
        read(8'h05, 16'h0000);
        @(posedge clk);
        ce <= 1'b0;
        write(8'h00, 16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        read(8'h00, expWord());
        complete_run();
    end
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            complete_run();
        end
    end
endmodule
`default_nettype wire
